// file: dps_host.sv
`timescale 1ns/1ps
// How it works
// - Strobe rises first; data held across it.
// - Strobe high whenever address lines change.
// - Pulse widened when output enable low.
// - Output enable high allows minimum pulse.
// - Address set up early, held after end.
// - Data stable before end; no hold needed.
// - Deselect before reading flag after write.
// - Flag write uses bit 0; 0 claims.
// - Flag address 3 bits; never both selects.
// - Host frees every flag at start-up.
module dps_host (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_cmd_valid,
   output logic o_cmd_ready,
   input wire dps_pkg::dps_cmd_t i_cmd,
   output logic o_rsp_valid,
   output logic [dps_pkg::DATA_W-1:0] o_rsp_data,
   output logic o_init_done,
   output dps_pkg::dps_pins_t o_pins,
   input wire logic [dps_pkg::DATA_W-1:0] i_dq
);
   import dps_pkg::*;

   dps_state_t state_q, state_d;
   dps_pins_t pins_q, pins_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [FLAG_ADDR_W:0] init_q, init_d;
   logic [DATA_W-1:0] rsp_data_q, rsp_data_d;
   logic rsp_valid_q, rsp_valid_d;
   logic after_flag_wr_q, after_flag_wr_d;
   logic [DATA_W-1:0] dq_s1_q, dq_s2_q, dq_s3_q;
   logic init_busy;
   dps_cmd_t cur_q, cur_d;
   logic [CW-1:0] low_cnt_q, low_cnt_d;

   // The data bus is asynchronous; only the agreed third-stage value is trusted.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         dq_s1_q <= '0;
         dq_s2_q <= '0;
         dq_s3_q <= '0;
      end else begin
         dq_s1_q <= i_dq;
         dq_s2_q <= dq_s1_q;
         dq_s3_q <= dq_s2_q;
      end
   end

   assign init_busy = ~init_q[FLAG_ADDR_W];
   assign o_cmd_ready = (state_q == S_IDLE) && !init_busy;
   assign o_rsp_valid = rsp_valid_q;
   assign o_rsp_data = rsp_data_q;
   assign o_init_done = ~init_busy;
   assign o_pins = pins_q;

   // Sequencer for one access; the strobes drop only after the address is already out.
   always_comb begin
      state_d = state_q;
      pins_d = pins_q;
      cnt_d = cnt_q;
      init_d = init_q;
      cur_d = cur_q;
      rsp_valid_d = 1'b0;
      rsp_data_d = rsp_data_q;
      after_flag_wr_d = after_flag_wr_q;
      case (state_q)
         S_IDLE: begin
            pins_d.mem_select_n = 1'b1;
            pins_d.flag_latch_select_n = 1'b1;
            pins_d.rw_n = 1'b1;
            pins_d.oe_n = 1'b1;
            pins_d.dq_oe = 1'b0;
            if (init_busy) begin
               // Flags come up undefined, so each is released once.
               cur_d = '0;
               cur_d.write = 1'b1;
               cur_d.flag = 1'b1;
               cur_d.addr[FLAG_ADDR_W-1:0] = init_q[FLAG_ADDR_W-1:0];
               cur_d.wdata[0] = FLAG_FREE;
               state_d = S_SETUP;
            end else if (i_cmd_valid) begin
               cur_d = i_cmd;
               state_d = S_SETUP;
            end
            if (state_d == S_SETUP) begin
               pins_d.addr = cur_d.flag ? {{(ADDR_W-FLAG_ADDR_W){1'b0}},
                  cur_d.addr[FLAG_ADDR_W-1:0]} : cur_d.addr;
               pins_d.dq_out = cur_d.flag ? {{(DATA_W-1){1'b1}}, cur_d.wdata[0]}
                  : cur_d.wdata;
            end
         end
         S_SETUP: begin
            // Only one select is ever low; the other stays high.
            pins_d.mem_select_n = cur_q.flag;
            pins_d.flag_latch_select_n = ~cur_q.flag;
            if (cur_q.write) begin
               pins_d.rw_n = 1'b0;
               pins_d.oe_n = 1'b1;
               pins_d.dq_oe = 1'b1;
               cnt_d = pins_q.oe_n ? WR_NARROW_CYC : WR_WIDE_CYC;
               state_d = S_WRITE;
            end else begin
               pins_d.oe_n = 1'b0;
               cnt_d = RD_CYC + SYNC_CYC;
               state_d = S_READ;
            end
         end
         S_WRITE: begin
            if (cnt_q > CNT_ONE) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               pins_d.rw_n = 1'b1;
               cnt_d = HOLD_CYC;
               state_d = S_HOLD;
            end
         end
         S_HOLD: begin
            // Strobe is already high, so address, data and select are still held.
            if (cnt_q > CNT_ONE) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               pins_d.mem_select_n = 1'b1;
               pins_d.flag_latch_select_n = 1'b1;
               pins_d.dq_oe = 1'b0;
               after_flag_wr_d = cur_q.flag;
               cnt_d = GAP_CYC;
               state_d = after_flag_wr_q || cur_q.flag ? S_GAP : S_IDLE;
               // An init write counts only once finished, so none of them answers.
               if (init_busy) begin
                  init_d = init_q + 1'b1;
               end
               rsp_valid_d = !init_busy;
            end
         end
         S_READ: begin
            // Data is taken only once the last two synchroniser stages agree.
            if (cnt_q > CNT_ONE) begin
               cnt_d = cnt_q - 1'b1;
            end else if (dq_s2_q == dq_s3_q) begin
               rsp_data_d = dq_s3_q;
               rsp_valid_d = 1'b1;
               pins_d.mem_select_n = 1'b1;
               pins_d.flag_latch_select_n = 1'b1;
               pins_d.oe_n = 1'b1;
               after_flag_wr_d = 1'b0;
               state_d = S_IDLE;
            end
         end
         S_GAP: begin
            // Selects and output enable stay high after a flag write, before the next access.
            if (cnt_q > CNT_ONE) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               state_d = S_IDLE;
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   // Registers of the sequencer; selects, strobe and output enable idle high, address and data low and undriven in reset.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= S_IDLE;
         pins_q <= '{mem_select_n: 1'b1, flag_latch_select_n: 1'b1, rw_n: 1'b1,
            oe_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
         cnt_q <= '0;
         init_q <= '0;
         cur_q <= '0;
         rsp_valid_q <= 1'b0;
         rsp_data_q <= '0;
         after_flag_wr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         pins_q <= pins_d;
         cnt_q <= cnt_d;
         init_q <= init_d;
         cur_q <= cur_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_data_q <= rsp_data_d;
         after_flag_wr_q <= after_flag_wr_d;
      end
   end

   // Counts the cycles of each write pulse so its width can be checked in nanoseconds.
   always_comb begin
      low_cnt_d = pins_q.rw_n ? '0 : low_cnt_q + 1'b1;
   end

   // Register of the pulse counter; it only serves the checks below.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         low_cnt_q <= '0;
      end else begin
         low_cnt_q <= low_cnt_d;
      end
   end

   // Address and data may only move while the strobe is high, and stay one cycle after.
   addr_stable_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !pins_q.rw_n |=> $stable(pins_q.addr))
      else $error("address moved during write strobe");
   init_free_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      init_busy && !pins_q.rw_n |-> !pins_q.flag_latch_select_n && pins_q.dq_out[0] == FLAG_FREE)
      else $error("init write is not a flag release");
   sel_exclusive_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      pins_q.mem_select_n || pins_q.flag_latch_select_n)
      else $error("both selects low");
   pulse_width_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      $rose(pins_q.rw_n) |-> int'(low_cnt_q) * CLK_NS >= WIDE_PULSE_NS)
      else $error("write pulse too short");
   data_setup_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      $rose(pins_q.rw_n) |-> pins_q.dq_oe && $stable(pins_q.dq_out))
      else $error("data not held to write end");
   sel_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      $rose(pins_q.rw_n) |-> !(pins_q.mem_select_n && pins_q.flag_latch_select_n))
      else $error("select rose before strobe");
   flag_bit_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !pins_q.flag_latch_select_n && !pins_q.rw_n |-> &pins_q.dq_out[DATA_W-1:1])
      else $error("flag write upper bits not idle");
   flag_gap_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      $rose(pins_q.flag_latch_select_n) && after_flag_wr_d |=> pins_q.flag_latch_select_n)
      else $error("flag reselected too soon");
   init_all_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_cmd_ready |-> init_q[FLAG_ADDR_W])
      else $error("command accepted before flags freed");
   oe_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !pins_q.rw_n |-> pins_q.oe_n)
      else $error("output enable low in write");
   read_done_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
      state_q == S_READ ##1 rsp_valid_q);
   flag_write_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
      state_q == S_GAP && !init_busy);
   mem_write_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
      !pins_q.rw_n && !pins_q.mem_select_n);
endmodule

// file: dps_mem_model.sv
`timescale 1ns/1ps
// Behavioural stand-in for the shared memory as seen from the host's port.
// The bench pokes mem and other_q directly to act as the far port.
module dps_mem_model (
   input wire logic i_sys_clk,
   input wire dps_pkg::dps_pins_t i_pins,
   output logic [dps_pkg::DATA_W-1:0] o_dq
);
   import dps_pkg::*;
   logic [DATA_W-1:0] mem [4096];
   logic [NUM_FLAGS-1:0] flag_q = 8'h00;
   logic [NUM_FLAGS-1:0] other_q = 8'h00;
   logic [NUM_FLAGS-1:0] pend_q = 8'h00;
   logic wr_q = 1'b0;
   logic wf_q = 1'b0;
   logic [ADDR_W-1:0] wa_q;
   logic [DATA_W-1:0] wd_q;
   logic [DATA_W-1:0] last_q = 8'h00;
   wire logic fsel = !i_pins.flag_latch_select_n;
   wire logic sel = !i_pins.mem_select_n || fsel;
   wire logic wr = sel && !i_pins.rw_n;
   wire logic rd = sel && i_pins.rw_n && !i_pins.oe_n;
   wire logic [DATA_W-1:0] val = fsel ? {DATA_W{flag_q[i_pins.addr[2:0]]}} :
      mem[i_pins.addr];
   // Floated lines show the inverse of the last value, so a stale sample is caught.
   assign o_dq = rd ? val : ~last_q;
   // A write lands when the strobe overlap ends; flags use bit 0 only.
   always @(posedge i_sys_clk) begin
      if (rd) last_q <= val;
      if (wr) begin
         wa_q <= i_pins.addr;
         wd_q <= i_pins.dq_out;
         wf_q <= fsel;
      end
      for (int k = 0; k < NUM_FLAGS; k++) begin
         if (pend_q[k] && !other_q[k]) begin
            flag_q[k] <= 1'b0;
            pend_q[k] <= 1'b0;
         end
      end
      // Words are not arbitrated; the bench pokes only words that no write is touching.
      if (wr_q && !wr) begin
         if (!wf_q) mem[wa_q] <= wd_q;
         else if (wd_q[0]) begin
            flag_q[wa_q[2:0]] <= 1'b1;
            pend_q[wa_q[2:0]] <= 1'b0;
         end else if (other_q[wa_q[2:0]]) pend_q[wa_q[2:0]] <= 1'b1;
         else flag_q[wa_q[2:0]] <= 1'b0;
      end
      wr_q <= wr;
   end
endmodule

// file: dps_pkg.sv
package dps_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int FLAG_ADDR_W = 3;
   localparam int NUM_FLAGS = 8;
   // Clock period and the documented times, in nanoseconds.
   localparam int CLK_NS = 40;
   localparam int MIN_WRITE_PULSE_NS = 12;
   localparam int WRITE_FLOAT_TIME_NS = 10;
   localparam int WRITE_DATA_SETUP_NS = 10;
   localparam int ADDR_SETUP_END_NS = 12;
   localparam int ADDR_HOLD_NS = 2;
   localparam int FLAG_UPDATE_GAP_NS = 15;
   localparam int FLAG_WRITE_TO_READ_DELAY_NS = 5;
   localparam int READ_ACCESS_NS = 25;
   localparam int CROSS_PORT_PULSE_DELAY_NS = 30;
   // Least times round up to whole cycles, never under one.
   function automatic int cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int FLOAT_PLUS_SETUP_NS = WRITE_FLOAT_TIME_NS + WRITE_DATA_SETUP_NS;
   localparam int WIDE_PULSE_NS = (FLOAT_PLUS_SETUP_NS > MIN_WRITE_PULSE_NS) ?
      FLOAT_PLUS_SETUP_NS : MIN_WRITE_PULSE_NS;
   localparam int CW = 4;
   localparam logic [CW-1:0] WR_NARROW_CYC = CW'(cyc(MIN_WRITE_PULSE_NS));
   localparam logic [CW-1:0] WR_WIDE_CYC = CW'(cyc(WIDE_PULSE_NS));
   localparam logic [CW-1:0] HOLD_CYC = CW'(cyc(ADDR_HOLD_NS));
   localparam logic [CW-1:0] GAP_CYC = CW'(cyc(FLAG_UPDATE_GAP_NS));
   localparam logic [CW-1:0] RD_CYC = CW'(cyc(READ_ACCESS_NS + FLAG_WRITE_TO_READ_DELAY_NS
      + CROSS_PORT_PULSE_DELAY_NS));
   localparam logic [CW-1:0] CNT_ONE = 4'h1;
   // Extra read cycles so the three-stage data synchroniser has caught up.
   localparam logic [CW-1:0] SYNC_CYC = 4'h3;
   localparam logic FLAG_CLAIM = 1'b0;
   localparam logic FLAG_FREE = 1'b1;

   // Command from the user side.
   typedef struct packed {
      logic write;
      logic flag;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dps_cmd_t;

   // Pins toward one port of the memory.
   typedef struct packed {
      logic mem_select_n;
      logic flag_latch_select_n;
      logic rw_n;
      logic oe_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
   } dps_pins_t;

   typedef enum logic [2:0] {S_IDLE, S_SETUP, S_WRITE, S_HOLD, S_READ, S_GAP} dps_state_t;
endpackage

// file: dual_port_sram_write_semaphore_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dual_port_sram_write_semaphore_tb;
   import dps_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cv = 1'b0;
   logic rdy, rv, idone, prw;
   dps_cmd_t cmd = '0;
   dps_pins_t pins;
   logic [DATA_W-1:0] rdat, dq, q, d;
   logic [ADDR_W-1:0] a, pa;
   int mismatches = 0;
   int n_compared = 0;
   int unsigned seed = 23;
   logic [DATA_W-1:0] rm [int];
   dps_host dut (.i_sys_clk(clk), .i_rst(rst), .i_cmd_valid(cv), .o_cmd_ready(rdy),
      .i_cmd(cmd), .o_rsp_valid(rv), .o_rsp_data(rdat), .o_init_done(idone),
      .o_pins(pins), .i_dq(dq));
   dps_mem_model m (.i_sys_clk(clk), .i_pins(pins), .o_dq(dq));
   // Free-running system clock.
   initial begin
      forever #20 clk = ~clk;
   end
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // One command: hold valid until taken, then wait for the answer pulse.
   task automatic op(input logic w, input logic f, input logic [ADDR_W-1:0] ad,
         input logic [DATA_W-1:0] wd);
      cmd = '{write: w, flag: f, addr: ad, wdata: wd};
      cv = 1'b1;
      while (rdy !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
      cv = 1'b0;
      while (rv !== 1'b1) @(posedge clk) #1;
      q = rdat;
   endtask
   // Strobe watch: output enable high and data driven through each pulse, address steady.
   always @(posedge clk) begin
      if (!rst && !pins.rw_n) begin
         `CHK({pins.oe_n, pins.dq_oe}, 2'h3)
      end
      if (!rst && (!pins.rw_n || !prw)) begin
         `CHK(pins.addr, pa)
      end
      pa <= pins.addr;
      prw <= pins.rw_n;
   end
   // Watchdog sized well past the expected run of under a thousand cycles.
   initial begin
      #400000;
      mismatches++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      while (idone !== 1'b1) @(posedge clk) #1;
      `CHK(m.flag_q, 8'hFF)
      for (int i = 0; i < 24; i++) begin
         a = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : ADDR_W'(xs());
         d = DATA_W'(xs());
         op(1'b1, 1'b0, a, d);
         rm[int'(a)] = d;
      end
      foreach (rm[k]) begin
         op(1'b0, 1'b0, ADDR_W'(k), 8'h00);
         `CHK(q, rm[k])
      end
      // The far port writes a word; the reference map follows it so later reads agree.
      a = ADDR_W'(xs());
      d = DATA_W'(xs());
      m.mem[a] = d;
      rm[int'(a)] = d;
      op(1'b0, 1'b0, a, 8'h00);
      `CHK(q, d)
      for (int k = 0; k < NUM_FLAGS; k++) begin
         m.other_q[k] = k[0];
         a = {(ADDR_W-FLAG_ADDR_W)'(xs()), FLAG_ADDR_W'(k)};
         op(1'b1, 1'b1, a, DATA_W'(xs()) & 8'hFE);
         op(1'b0, 1'b1, a, 8'h00);
         `CHK(q, k[0] ? 8'hFF : 8'h00)
         m.other_q[k] = 1'b0;
         op(1'b0, 1'b1, a, 8'h00);
         `CHK(q, 8'h00)
         op(1'b1, 1'b1, a, DATA_W'(xs()) | 8'h01);
         op(1'b0, 1'b1, a, 8'h00);
         `CHK(q, 8'hFF)
      end
      rst = 1'b1;
      #5;
      `CHK({pins.mem_select_n, pins.flag_latch_select_n, pins.rw_n, pins.dq_oe}, 4'hE)
      @(posedge clk) #1 rst = 1'b0;
      while (idone !== 1'b1) @(posedge clk) #1;
      op(1'b0, 1'b0, 12'hFFF, 8'h00);
      `CHK(q, rm[32'hFFF])
      test_done();
   end
endmodule
